// File: isa_opt_pkg.sv
// Constants, operation codes and state types for the core option unit.
// Assumes a single core clock and that every user sees this package.
`default_nettype none
package isa_opt_pkg;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int  ENDIAN_BIT  = 7;
  localparam int  DSP_ACC_BIT = 0;
  localparam logic [3:0] DSP_CP_NUM = 4'h0;
  localparam int  DW_ALIGN_W  = 3;
  localparam int  LINE_OFS_W  = 5;
  localparam int  ACC_W       = 40;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CPAR_RST = 32'h0000_0000;
  localparam logic [31:0] SAT_MAX  = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_MIN  = 32'h8000_0000;
  localparam logic [2:0] STEP_ARM   = 3'h4;
  localparam logic [2:0] STEP_SHORT = 3'h2;
  // ****************************************
  // Access sizes and page attributes
  // ****************************************
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [3:0] BE_ALL  = 4'hF;
  localparam logic [3:0] BE_LOHALF = 4'h3;
  localparam logic [3:0] BE_HIHALF = 4'hC;
  localparam logic [3:0] BE_BYTE0  = 4'h1;
  localparam logic [2:0] PA_UNCACHED = 3'h0;
  localparam logic [2:0] PA_BUFFERED = 3'h1;
  localparam logic [2:0] PA_WTHRU    = 3'h2;
  localparam logic [2:0] PA_WBACK    = 3'h3;
  localparam logic [2:0] PA_RSVD     = 3'h4;
  localparam logic [2:0] PA_COALESCE = 3'h5;
  localparam logic [2:0] PA_MINI     = 3'h6;
  localparam logic [2:0] PA_WALLOC   = 3'h7;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    OP_NONE, OP_HW_MULT, OP_HW_ACC32, OP_WH_MULT, OP_WH_ACC,
    OP_HW_ACC64, OP_SAT_ADD, OP_SAT_SUB, OP_DSAT_ADD, OP_DSAT_SUB,
    OP_LOAD, OP_STORE, OP_DW_LOAD, OP_DW_STORE, OP_PRELOAD,
    OP_CP_WRITE2, OP_CP_READ2, OP_MIA, OP_MIA_PH, OP_MIA_XY,
    OP_FLUSH, OP_CLEAN
  } op_t;
  typedef enum logic [1:0] {CL_IDLE, CL_SCAN, CL_WAIT} clean_t;
endpackage : isa_opt_pkg
`default_nettype wire

// File: isa_opt_core.sv
// Instruction option unit: endian control, DSP arithmetic, the DSP
// coprocessor accumulator, load/store checks, cache maintenance state,
// page attribute decode, performance counters and breakpoints.
// Assumes every input comes from core logic on MCLK_IN.
//
// Operation
// - Endian choice comes from bit 7 of control register 1.
// - Reset gives little-endian; bit acts regardless of translation.
// - Endian bit steers data path, fill and write buffers, lanes; here it only flips the store byte-enable lanes.
// - Legacy 26-bit address mode is unsupported.
// - Compressed 16-bit instructions run alongside 32-bit ones.
// - Signed halfword multiplies with 32-bit and 64-bit accumulation.
// - Saturating add and subtract, plus doubled-operand variants.
// - Preload hints are checked by the MMU as reads.
// - Preload hints never raise data breakpoints.
// - Preload to uncached page or resident line does nothing.
// - Double-word load and store fault unless 64-bit aligned.
// - Two-register transfers only to the DSP coprocessor.
// - Aborted writeback leaves the base register unchanged.
// - DSP coprocessor holds one 40-bit accumulator, 8 operations.
// - Page attributes gain a bit for write-allocate and mini cache.
// - Two performance counters, each selecting one event.
// - Two instruction, one data and one masked data breakpoint.
// - Flush clears the valid and dirty bits of the addressed line only and writes nothing back.
// - Clean writes every dirty line back.
// - DSP coprocessor access needs bit 0 of access register.
`default_nettype none
module isa_opt_core #(
  parameter int NLINES = 8,
  parameter int NPMC   = 2,
  parameter int NEVT   = 8
) (
  input  wire logic        MCLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic        CTRL_WR_IN,
  input  wire logic [31:0] CTRL_WDATA_IN,
  output logic      [31:0] CTRL_RDATA_OUT,
  input  wire logic        CPAR_WR_IN,
  input  wire logic [31:0] CPAR_WDATA_IN,
  output logic      [31:0] CPAR_RDATA_OUT,
  input  wire logic        INSN_VALID_IN,
  output logic             INSN_READY_OUT,
  input  wire isa_opt_pkg::op_t OP_IN,
  input  wire logic [3:0]  COPROC_IN,
  input  wire logic [4:0]  MODE_IN,
  input  wire logic        SHORT_SET_IN,
  input  wire logic        SEL_X_IN,
  input  wire logic        SEL_Y_IN,
  input  wire logic [31:0] OPA_IN,
  input  wire logic [31:0] OPB_IN,
  input  wire logic [31:0] OPC_IN,
  input  wire logic [31:0] OPD_IN,
  input  wire logic [31:0] ADDR_IN,
  input  wire logic [1:0]  SIZE_IN,
  input  wire logic [2:0]  PAGE_XCB_IN,
  input  wire logic        ABORT_IN,
  input  wire logic        WRITEBACK_IN,
  input  wire logic [31:0] NEW_BASE_IN,
  input  wire logic [31:0] PC_IN,
  input  wire logic [31:0] IBKPT0_IN,
  input  wire logic [31:0] IBKPT1_IN,
  input  wire logic [31:0] DBKPT0_IN,
  input  wire logic [31:0] DBKPT1_IN,
  input  wire logic [31:0] DBKPT_MASK_IN,
  input  wire logic [3:0]  BKPT_EN_IN,
  input  wire logic [NEVT-1:0] EVENTS_IN,
  input  wire logic [NPMC*$clog2(NEVT)-1:0] PMC_SEL_IN,
  input  wire logic        WB_ACK_IN,
  output logic      [31:0] RESULT_OUT,
  output logic      [31:0] RESULT_HI_OUT,
  output logic             SAT_FLAG_OUT,
  output logic             UNDEF_OUT,
  output logic             ALIGN_FAULT_OUT,
  output logic             BASE_WE_OUT,
  output logic      [31:0] BASE_OUT,
  output logic             MMU_REQ_OUT,
  output logic             MMU_WRITE_OUT,
  output logic             PRELOAD_FILL_OUT,
  output logic             BIG_ENDIAN_OUT,
  output logic      [3:0]  BYTE_EN_OUT,
  output logic      [31:0] STORE_DATA_OUT,
  output logic      [2:0]  FETCH_STEP_OUT,
  output logic      [39:0] ACC_OUT,
  output logic             IBKPT_HIT_OUT,
  output logic             DBKPT_HIT_OUT,
  output logic             WB_REQ_OUT,
  output logic [$clog2(NLINES)-1:0] WB_IDX_OUT,
  output logic             CLEAN_BUSY_OUT,
  output logic [NPMC*32-1:0] PMC_COUNT_OUT
);
  localparam int IW = $clog2(NLINES);
  localparam int SW = $clog2(NEVT);
  if (NLINES < 2 || NPMC < 1 || NEVT < 2 ||
      (NLINES & (NLINES - 1)) != 0 ||
      (NEVT & (NEVT - 1)) != 0) begin : g_bad_param
    $error("isa_opt_core: unsupported parameter values");
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic ctrl_big_r;
  logic cpar_dsp_r;
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      ctrl_big_r <= isa_opt_pkg::CTRL_RST[isa_opt_pkg::ENDIAN_BIT];
    end else if (CTRL_WR_IN) begin
      ctrl_big_r <= CTRL_WDATA_IN[isa_opt_pkg::ENDIAN_BIT];
    end
  end
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      cpar_dsp_r <= isa_opt_pkg::CPAR_RST[isa_opt_pkg::DSP_ACC_BIT];
    end else if (CPAR_WR_IN) begin
      cpar_dsp_r <= CPAR_WDATA_IN[isa_opt_pkg::DSP_ACC_BIT];
    end
  end
  always_comb begin
    CTRL_RDATA_OUT = '0;
    CTRL_RDATA_OUT[isa_opt_pkg::ENDIAN_BIT] = ctrl_big_r;
    CPAR_RDATA_OUT = '0;
    CPAR_RDATA_OUT[isa_opt_pkg::DSP_ACC_BIT] = cpar_dsp_r;
  end
  // The endian bit is not gated by translation enable.
  assign BIG_ENDIAN_OUT = ctrl_big_r;

  // ****************************************
  // Decode and checks
  // ****************************************
  isa_opt_pkg::clean_t cl_r;
  logic    take;
  logic    legacy;
  logic    two_reg;
  logic    dsp_acc;
  logic    undef;
  logic    dw_op;
  logic    mem_op;
  logic    is_wr;
  logic    ok;
  logic [IW-1:0] idx;
  logic [NLINES-1:0] valid_r;
  logic [NLINES-1:0] dirty_r;
  logic    cacheable;
  logic    walloc;
  logic    wback;

  assign INSN_READY_OUT = (cl_r == isa_opt_pkg::CL_IDLE);
  assign take    = INSN_VALID_IN && INSN_READY_OUT;
  assign legacy  = !MODE_IN[4];
  assign two_reg = OP_IN == isa_opt_pkg::OP_CP_WRITE2 ||
                   OP_IN == isa_opt_pkg::OP_CP_READ2;
  assign dsp_acc = OP_IN == isa_opt_pkg::OP_MIA ||
                   OP_IN == isa_opt_pkg::OP_MIA_PH ||
                   OP_IN == isa_opt_pkg::OP_MIA_XY ||
                   (two_reg && COPROC_IN == isa_opt_pkg::DSP_CP_NUM);
  assign undef = legacy ||
    (two_reg && COPROC_IN != isa_opt_pkg::DSP_CP_NUM) ||
    (dsp_acc && !cpar_dsp_r);
  assign dw_op  = OP_IN == isa_opt_pkg::OP_DW_LOAD ||
                  OP_IN == isa_opt_pkg::OP_DW_STORE;
  assign is_wr  = OP_IN == isa_opt_pkg::OP_STORE ||
                  OP_IN == isa_opt_pkg::OP_DW_STORE;
  assign mem_op = dw_op || is_wr || OP_IN == isa_opt_pkg::OP_LOAD;
  assign ok     = take && !undef;
  assign idx    = ADDR_IN[isa_opt_pkg::LINE_OFS_W +: IW];
  always_comb begin
    cacheable = 1'b1;
    walloc    = 1'b0;
    wback     = 1'b0;
    case (PAGE_XCB_IN)
      isa_opt_pkg::PA_UNCACHED,
      isa_opt_pkg::PA_BUFFERED,
      isa_opt_pkg::PA_RSVD,
      isa_opt_pkg::PA_COALESCE: cacheable = 1'b0;
      isa_opt_pkg::PA_WTHRU: wback = 1'b0;
      isa_opt_pkg::PA_WBACK: wback = 1'b1;
      isa_opt_pkg::PA_MINI: wback = 1'b1;
      isa_opt_pkg::PA_WALLOC: begin
        wback  = 1'b1;
        walloc = 1'b1;
      end
      default: cacheable = 1'b0;
    endcase
  end

  // ****************************************
  // Arithmetic
  // ****************************************
  function automatic logic [32:0] sat(input logic [32:0] v);
    logic ovf;
    ovf = v[32] ^ v[31];
    if (!ovf) begin
      sat = {1'b0, v[31:0]};
    end else if (v[32]) begin
      sat = {1'b1, isa_opt_pkg::SAT_MIN};
    end else begin
      sat = {1'b1, isa_opt_pkg::SAT_MAX};
    end
  endfunction : sat

  logic signed [15:0] ha, hb;
  logic signed [31:0] p16, ph_lo, ph_hi;
  logic signed [47:0] pwh;
  logic signed [63:0] pw;
  logic [32:0] s32, dbl, qa, qs, qn;
  logic [63:0] s64;
  logic [31:0] wh;
  always_comb begin
    ha    = SEL_X_IN ? OPA_IN[31:16] : OPA_IN[15:0];
    hb    = SEL_Y_IN ? OPB_IN[31:16] : OPB_IN[15:0];
    p16   = ha * hb;
    pwh   = $signed(OPA_IN) * hb;
    wh    = pwh[47:16];
    pw    = $signed(OPA_IN) * $signed(OPB_IN);
    ph_lo = $signed(OPA_IN[15:0]) * $signed(OPB_IN[15:0]);
    ph_hi = $signed(OPA_IN[31:16]) * $signed(OPB_IN[31:16]);
    s32   = (OP_IN == isa_opt_pkg::OP_WH_ACC) ?
            {wh[31], wh} + {OPC_IN[31], OPC_IN} :
            {p16[31], p16} + {OPC_IN[31], OPC_IN};
    s64   = {OPD_IN, OPC_IN} + {{32{p16[31]}}, p16};
    dbl   = sat({OPB_IN, 1'b0});
    qa    = sat({OPA_IN[31], OPA_IN} + {dbl[31], dbl[31:0]});
    qs    = sat({OPA_IN[31], OPA_IN} - {dbl[31], dbl[31:0]});
    qn    = sat((OP_IN == isa_opt_pkg::OP_SAT_ADD) ?
            {OPA_IN[31], OPA_IN} + {OPB_IN[31], OPB_IN} :
            {OPA_IN[31], OPA_IN} - {OPB_IN[31], OPB_IN});
  end

  // ****************************************
  // Results
  // ****************************************
  logic [39:0] acc_r;
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      RESULT_OUT    <= '0;
      RESULT_HI_OUT <= '0;
      SAT_FLAG_OUT  <= 1'b0;
    end else if (ok) begin
      SAT_FLAG_OUT <= 1'b0;
      case (OP_IN)
        isa_opt_pkg::OP_HW_MULT: RESULT_OUT <= p16;
        isa_opt_pkg::OP_WH_MULT: RESULT_OUT <= wh;
        isa_opt_pkg::OP_HW_ACC32, isa_opt_pkg::OP_WH_ACC: begin
          RESULT_OUT   <= s32[31:0];
          SAT_FLAG_OUT <= s32[32] ^ s32[31];
        end
        isa_opt_pkg::OP_HW_ACC64: begin
          RESULT_OUT    <= s64[31:0];
          RESULT_HI_OUT <= s64[63:32];
        end
        isa_opt_pkg::OP_SAT_ADD, isa_opt_pkg::OP_SAT_SUB: begin
          RESULT_OUT   <= qn[31:0];
          SAT_FLAG_OUT <= qn[32];
        end
        isa_opt_pkg::OP_DSAT_ADD: begin
          RESULT_OUT   <= qa[31:0];
          SAT_FLAG_OUT <= qa[32] | dbl[32];
        end
        isa_opt_pkg::OP_DSAT_SUB: begin
          RESULT_OUT   <= qs[31:0];
          SAT_FLAG_OUT <= qs[32] | dbl[32];
        end
        isa_opt_pkg::OP_CP_READ2: begin
          RESULT_OUT    <= acc_r[31:0];
          RESULT_HI_OUT <= {{24{acc_r[39]}}, acc_r[39:32]};
        end
        default: RESULT_OUT <= RESULT_OUT;
      endcase
    end
  end

  // The single internal accumulator of the DSP coprocessor.
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      acc_r <= '0;
    end else if (ok) begin
      case (OP_IN)
        isa_opt_pkg::OP_MIA: acc_r <= acc_r + pw[39:0];
        isa_opt_pkg::OP_MIA_PH:
          acc_r <= acc_r + {{8{ph_lo[31]}}, ph_lo}
                         + {{8{ph_hi[31]}}, ph_hi};
        isa_opt_pkg::OP_MIA_XY: acc_r <= acc_r + {{8{p16[31]}}, p16};
        isa_opt_pkg::OP_CP_WRITE2: acc_r <= {OPB_IN[7:0], OPA_IN};
        default: acc_r <= acc_r;
      endcase
    end
  end
  assign ACC_OUT = acc_r;

  // ****************************************
  // Memory access side effects
  // ****************************************
  logic misalign;
  assign misalign = dw_op && (ADDR_IN[isa_opt_pkg::DW_ALIGN_W-1:0] != '0);
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      UNDEF_OUT        <= 1'b0;
      ALIGN_FAULT_OUT  <= 1'b0;
      BASE_WE_OUT      <= 1'b0;
      BASE_OUT         <= '0;
      MMU_REQ_OUT      <= 1'b0;
      MMU_WRITE_OUT    <= 1'b0;
      PRELOAD_FILL_OUT <= 1'b0;
      FETCH_STEP_OUT   <= isa_opt_pkg::STEP_ARM;
    end else begin
      UNDEF_OUT       <= take && undef;
      ALIGN_FAULT_OUT <= ok && misalign;
      // A data abort suppresses the base update.
      BASE_WE_OUT <= ok && mem_op && WRITEBACK_IN && !ABORT_IN
                     && !misalign;
      if (ok && mem_op && WRITEBACK_IN && !ABORT_IN) begin
        BASE_OUT <= NEW_BASE_IN;
      end
      MMU_REQ_OUT <= ok && (mem_op || OP_IN == isa_opt_pkg::OP_PRELOAD);
      MMU_WRITE_OUT <= ok && is_wr;
      PRELOAD_FILL_OUT <= ok && OP_IN == isa_opt_pkg::OP_PRELOAD &&
                          cacheable && !valid_r[idx];
      FETCH_STEP_OUT <= SHORT_SET_IN ? isa_opt_pkg::STEP_SHORT
                                     : isa_opt_pkg::STEP_ARM;
    end
  end

  // Sub-word lanes flip with the endian bit.
  logic [1:0] lane;
  assign lane = ctrl_big_r ? ~ADDR_IN[1:0] : ADDR_IN[1:0];
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      BYTE_EN_OUT    <= '0;
      STORE_DATA_OUT <= '0;
    end else if (ok && is_wr) begin
      case (SIZE_IN)
        isa_opt_pkg::SZ_BYTE: begin
          BYTE_EN_OUT    <= isa_opt_pkg::BE_BYTE0 << lane;
          STORE_DATA_OUT <= {4{OPB_IN[7:0]}};
        end
        isa_opt_pkg::SZ_HALF: begin
          BYTE_EN_OUT    <= lane[1] ? isa_opt_pkg::BE_HIHALF
                                    : isa_opt_pkg::BE_LOHALF;
          STORE_DATA_OUT <= {2{OPB_IN[15:0]}};
        end
        default: begin
          BYTE_EN_OUT    <= isa_opt_pkg::BE_ALL;
          STORE_DATA_OUT <= OPB_IN;
        end
      endcase
    end else begin
      BYTE_EN_OUT <= '0;
    end
  end

  // ****************************************
  // Breakpoints
  // ****************************************
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      IBKPT_HIT_OUT <= 1'b0;
      DBKPT_HIT_OUT <= 1'b0;
    end else begin
      IBKPT_HIT_OUT <= take && ((BKPT_EN_IN[0] && PC_IN == IBKPT0_IN) ||
                       (BKPT_EN_IN[1] && PC_IN == IBKPT1_IN));
      // Only real loads and stores are compared; preload is not.
      DBKPT_HIT_OUT <= ok && mem_op &&
        ((BKPT_EN_IN[2] && ADDR_IN == DBKPT0_IN) ||
         (BKPT_EN_IN[3] && ((ADDR_IN ^ DBKPT1_IN) & ~DBKPT_MASK_IN)
                           == '0));
    end
  end

  // ****************************************
  // Cache line state and clean walker
  // ****************************************
  logic [IW-1:0] scan_r;
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      valid_r <= '0;
      dirty_r <= '0;
    end else if (cl_r == isa_opt_pkg::CL_WAIT && WB_ACK_IN) begin
      dirty_r[scan_r] <= 1'b0;
    end else if (ok && OP_IN == isa_opt_pkg::OP_FLUSH) begin
      valid_r[idx] <= 1'b0;
      dirty_r[idx] <= 1'b0;
    end else if (ok && !misalign && !ABORT_IN && cacheable) begin
      if (OP_IN == isa_opt_pkg::OP_PRELOAD ||
          (mem_op && !is_wr)) begin
        valid_r[idx] <= 1'b1;
      end else if (is_wr && (valid_r[idx] || walloc)) begin
        valid_r[idx] <= 1'b1;
        dirty_r[idx] <= wback;
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      cl_r   <= isa_opt_pkg::CL_IDLE;
      scan_r <= '0;
    end else begin
      case (cl_r)
        isa_opt_pkg::CL_IDLE: begin
          scan_r <= '0;
          if (ok && OP_IN == isa_opt_pkg::OP_CLEAN) begin
            cl_r <= isa_opt_pkg::CL_SCAN;
          end
        end
        isa_opt_pkg::CL_SCAN: begin
          if (valid_r[scan_r] && dirty_r[scan_r]) begin
            cl_r <= isa_opt_pkg::CL_WAIT;
          end else if (scan_r == IW'(NLINES - 1)) begin
            cl_r <= isa_opt_pkg::CL_IDLE;
          end else begin
            scan_r <= scan_r + 1'b1;
          end
        end
        isa_opt_pkg::CL_WAIT: begin
          if (WB_ACK_IN) begin
            cl_r <= isa_opt_pkg::CL_SCAN;
          end
        end
        default: cl_r <= isa_opt_pkg::CL_IDLE;
      endcase
    end
  end
  assign WB_REQ_OUT     = (cl_r == isa_opt_pkg::CL_WAIT);
  assign WB_IDX_OUT     = scan_r;
  assign CLEAN_BUSY_OUT = (cl_r != isa_opt_pkg::CL_IDLE);

  // ****************************************
  // Performance counters
  // ****************************************
  for (genvar g = 0; g < NPMC; g++) begin : g_pmc
    logic [31:0] cnt_r;
    always_ff @(posedge MCLK_IN) begin
      if (SYS_RST_IN) begin
        cnt_r <= '0;
      end else if (EVENTS_IN[PMC_SEL_IN[g*SW +: SW]]) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
    assign PMC_COUNT_OUT[g*32 +: 32] = cnt_r;
  end
endmodule : isa_opt_core
`default_nettype wire

// File: isa_opt_chk.sv
// Assertion checker for the core option unit, bound to isa_opt_core.
// Assumes isa_opt_pkg is compiled first and a single clock domain.
`default_nettype none
module isa_opt_chk (
  input wire logic             MCLK_IN,
  input wire logic             SYS_RST_IN,
  input wire logic             CTRL_WR_IN,
  input wire logic [31:0]      CTRL_WDATA_IN,
  input wire logic [31:0]      CPAR_RDATA_OUT,
  input wire logic             INSN_VALID_IN,
  input wire logic             INSN_READY_OUT,
  input wire isa_opt_pkg::op_t OP_IN,
  input wire logic [3:0]       COPROC_IN,
  input wire logic [4:0]       MODE_IN,
  input wire logic [31:0]      ADDR_IN,
  input wire logic             ABORT_IN,
  input wire logic             UNDEF_OUT,
  input wire logic             ALIGN_FAULT_OUT,
  input wire logic             BASE_WE_OUT,
  input wire logic             MMU_WRITE_OUT,
  input wire logic             BIG_ENDIAN_OUT,
  input wire logic             DBKPT_HIT_OUT,
  input wire logic             CLEAN_BUSY_OUT
);
  // ****************************************
  // Properties
  // ****************************************
  logic tk;
  logic dw;
  logic cp2;
  assign tk  = INSN_VALID_IN && INSN_READY_OUT;
  assign dw  = OP_IN inside {isa_opt_pkg::OP_DW_LOAD,
    isa_opt_pkg::OP_DW_STORE};
  assign cp2 = OP_IN inside {isa_opt_pkg::OP_CP_WRITE2,
                             isa_opt_pkg::OP_CP_READ2};
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  property p_rst; $fell(SYS_RST_IN) |-> !BIG_ENDIAN_OUT; endproperty
  a_rst: assert property (p_rst)
    else $error("endian bit set after reset");
  property p_end;
    CTRL_WR_IN |=> BIG_ENDIAN_OUT == $past(CTRL_WDATA_IN[7]);
  endproperty
  a_end: assert property (p_end)
    else $error("endian output does not follow control bit");
  property p_dw;
    tk && MODE_IN[4] && dw
      |=> ALIGN_FAULT_OUT == ($past(ADDR_IN[2:0]) != 3'h0);
  endproperty
  a_dw: assert property (p_dw)
    else $error("double-word alignment fault wrong");
  property p_cpo; tk && MODE_IN[4] && cp2 && COPROC_IN != 4'h0 |=> UNDEF_OUT;
  endproperty
  a_cpo: assert property (p_cpo)
    else $error("transfer to other coprocessor not undefined");
  property p_cpd; tk && cp2 && !CPAR_RDATA_OUT[0] |=> UNDEF_OUT; endproperty
  a_cpd: assert property (p_cpd)
    else $error("disabled coprocessor access not undefined");
  property p_leg;
    tk && !MODE_IN[4] && OP_IN != isa_opt_pkg::OP_NONE |=> UNDEF_OUT;
  endproperty
  a_leg: assert property (p_leg)
    else $error("legacy mode instruction not undefined");
  property p_abt; tk && ABORT_IN |=> !BASE_WE_OUT; endproperty
  a_abt: assert property (p_abt)
    else $error("base written on abort");
  property p_pld;
    tk && OP_IN == isa_opt_pkg::OP_PRELOAD
      |=> !MMU_WRITE_OUT && !DBKPT_HIT_OUT;
  endproperty
  a_pld: assert property (p_pld)
    else $error("preload seen as write or breakpoint");
  property p_cln;
    tk && MODE_IN[4] && OP_IN == isa_opt_pkg::OP_CLEAN
      |=> CLEAN_BUSY_OUT && !INSN_READY_OUT;
  endproperty
  a_cln: assert property (p_cln)
    else $error("clean did not start");
  c_cln: cover property (tk && OP_IN == isa_opt_pkg::OP_CLEAN);
  c_flt: cover property (ALIGN_FAULT_OUT);
  c_und: cover property (UNDEF_OUT);
endmodule : isa_opt_chk
bind isa_opt_core isa_opt_chk chk_i (
  .MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .CTRL_WR_IN(CTRL_WR_IN),
  .CTRL_WDATA_IN(CTRL_WDATA_IN), .CPAR_RDATA_OUT(CPAR_RDATA_OUT),
  .INSN_VALID_IN(INSN_VALID_IN), .INSN_READY_OUT(INSN_READY_OUT),
  .OP_IN(OP_IN), .COPROC_IN(COPROC_IN), .MODE_IN(MODE_IN), .ADDR_IN(ADDR_IN),
  .ABORT_IN(ABORT_IN), .UNDEF_OUT(UNDEF_OUT),
  .ALIGN_FAULT_OUT(ALIGN_FAULT_OUT), .BASE_WE_OUT(BASE_WE_OUT),
  .MMU_WRITE_OUT(MMU_WRITE_OUT), .BIG_ENDIAN_OUT(BIG_ENDIAN_OUT),
  .DBKPT_HIT_OUT(DBKPT_HIT_OUT), .CLEAN_BUSY_OUT(CLEAN_BUSY_OUT)
);
`default_nettype wire

// File: core_isa_implementation_options_test.sv
// Self-checking bench for the core option unit isa_opt_core.
// Assumes isa_opt_pkg and the checker are compiled before it.
`default_nettype none
module core_isa_implementation_options_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, cwr = 1'b0, pwr = 1'b0, vld = 1'b0;
  logic        shrt = 1'b0, sx = 1'b0, sy = 1'b0, abt = 1'b0, wbk = 1'b0;
  logic        ack = 1'b0;
  logic [31:0] cwd = 32'h0, pwd = 32'h0, opa = 32'h0, opb = 32'h0;
  logic [31:0] opc = 32'h0, opd = 32'h0, adr = 32'h0, nb = 32'h0;
  logic [31:0] ib = 32'h0, dbk = 32'h0;
  logic [3:0]  cop = 4'h0, ben = 4'h5;
  logic [4:0]  mode = 5'h13;
  logic [1:0]  sz = 2'h2;
  logic [2:0]  xcb = 3'h0;
  logic [7:0]  evt = 8'h0;
  logic [5:0]  psel = 6'h0;
  isa_opt_pkg::op_t op = isa_opt_pkg::OP_NONE;
  logic [31:0] crd, prd, res, rhi, base, sdat;
  logic        rdy, sat, und, alf, bwe, mreq, mwr, pfl, bend, ihit, dhit;
  logic        wreq, busy;
  logic [3:0]  bye;
  logic [2:0]  step, widx;
  logic [39:0] acc;
  logic [63:0] pmc;
  int          failures = 0;
  int          checks_done = 0;
  always #2 clk = ~clk;
  isa_opt_core dut (
    .MCLK_IN(clk), .SYS_RST_IN(rst), .CTRL_WR_IN(cwr), .CTRL_WDATA_IN(cwd),
    .CTRL_RDATA_OUT(crd), .CPAR_WR_IN(pwr), .CPAR_WDATA_IN(pwd),
    .CPAR_RDATA_OUT(prd), .INSN_VALID_IN(vld), .INSN_READY_OUT(rdy),
    .OP_IN(op), .COPROC_IN(cop), .MODE_IN(mode), .SHORT_SET_IN(shrt),
    .SEL_X_IN(sx), .SEL_Y_IN(sy), .OPA_IN(opa), .OPB_IN(opb), .OPC_IN(opc),
    .OPD_IN(opd), .ADDR_IN(adr), .SIZE_IN(sz), .PAGE_XCB_IN(xcb),
    .ABORT_IN(abt), .WRITEBACK_IN(wbk), .NEW_BASE_IN(nb), .PC_IN(ib),
    .IBKPT0_IN(ib), .IBKPT1_IN(ib), .DBKPT0_IN(dbk), .DBKPT1_IN(ib),
    .DBKPT_MASK_IN(ib), .BKPT_EN_IN(ben), .EVENTS_IN(evt),
    .PMC_SEL_IN(psel), .WB_ACK_IN(ack), .RESULT_OUT(res),
    .RESULT_HI_OUT(rhi), .SAT_FLAG_OUT(sat), .UNDEF_OUT(und),
    .ALIGN_FAULT_OUT(alf), .BASE_WE_OUT(bwe), .BASE_OUT(base),
    .MMU_REQ_OUT(mreq), .MMU_WRITE_OUT(mwr), .PRELOAD_FILL_OUT(pfl),
    .BIG_ENDIAN_OUT(bend), .BYTE_EN_OUT(bye), .STORE_DATA_OUT(sdat),
    .FETCH_STEP_OUT(step), .ACC_OUT(acc), .IBKPT_HIT_OUT(ihit),
    .DBKPT_HIT_OUT(dhit), .WB_REQ_OUT(wreq), .WB_IDX_OUT(widx),
    .CLEAN_BUSY_OUT(busy), .PMC_COUNT_OUT(pmc)
  );
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input isa_opt_pkg::op_t o);
    @(negedge clk);
    op = o;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
  endtask : run
  task automatic wr_ctl(input logic c, input logic [31:0] d);
    cwd = c ? d : cwd;
    pwd = c ? pwd : d;
    cwr = c;
    pwr = !c;
    @(negedge clk);
    cwr = 1'b0;
    pwr = 1'b0;
  endtask : wr_ctl
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_endian();
    chk({crd, prd}, 64'h0);
    chk({bend, step, rdy}, {1'b0, 3'h4, 1'b1});
    wr_ctl(1'b1, 32'h80);
    chk({crd, 31'h0, bend}, {32'h80, 32'h1});
    sz = 2'h0;
    opb = 32'hA5;
    run(isa_opt_pkg::OP_STORE);
    chk({sdat, 28'h0, bye}, {32'hA5A5A5A5, 32'h8});
    wr_ctl(1'b1, 32'h0);
    run(isa_opt_pkg::OP_STORE);
    chk(bye, 64'h1);
    sz = 2'h2;
  endtask : t_endian
  task automatic t_dsp();
    isa_opt_pkg::op_t ops[4] = '{isa_opt_pkg::OP_SAT_ADD,
      isa_opt_pkg::OP_SAT_SUB, isa_opt_pkg::OP_DSAT_ADD,
      isa_opt_pkg::OP_DSAT_SUB};
    logic [31:0] a[4] = '{32'h7FFFFFFF, 32'h80000000, 32'h40000000,
      32'hC0000000};
    logic [31:0] b[4] = '{32'h1, 32'h1, 32'h40000000, 32'hC0000000};
    logic [31:0] r[4] = '{32'h7FFFFFFF, 32'h80000000, 32'h7FFFFFFF,
      32'h40000000};
    for (int i = 0; i < 4; i++) begin
      opa = a[i];
      opb = b[i];
      run(ops[i]);
      chk({res, 31'h0, sat}, {r[i], 31'h0, i < 3});
    end
    opa = 32'h00030000;
    opb = 32'h0000FFFE;
    opc = 32'hFFFFFFFF;
    sx = 1'b1;
    run(isa_opt_pkg::OP_HW_MULT);
    chk(res, 64'hFFFFFFFA);
    run(isa_opt_pkg::OP_HW_ACC64);
    chk({rhi, res}, 64'hFFFFFFF9);
    sx = 1'b0;
  endtask : t_dsp
  task automatic t_cp();
    wr_ctl(1'b0, 32'h1);
    chk(prd, 64'h1);
    opa = 32'h12345678;
    opb = 32'hAB;
    run(isa_opt_pkg::OP_CP_WRITE2);
    chk(acc, 64'hAB12345678);
    run(isa_opt_pkg::OP_CP_READ2);
    chk({rhi, res}, 64'hFFFFFFAB12345678);
    cop = 4'h1;
    opb = 32'h0;
    run(isa_opt_pkg::OP_CP_WRITE2);
    chk({acc, und}, {40'hAB12345678, 1'b1});
    cop = 4'h0;
    wr_ctl(1'b0, 32'h0);
    run(isa_opt_pkg::OP_CP_READ2);
    chk(und, 64'h1);
    mode = 5'h03;
    run(isa_opt_pkg::OP_SAT_ADD);
    chk(und, 64'h1);
    mode = 5'h13;
    for (int i = 1; i < 5; i++) begin
      adr = 32'(i * 4);
      run(i[1] ? isa_opt_pkg::OP_DW_STORE : isa_opt_pkg::OP_DW_LOAD);
      chk(alf, {63'h0, i[0]});
    end
  endtask : t_cp
  task automatic t_mem();
    nb = 32'h1000;
    wbk = 1'b1;
    adr = 32'h0;
    run(isa_opt_pkg::OP_LOAD);
    chk({bwe, base}, {1'b1, 32'h1000});
    chk({ihit, dhit}, 64'h3);
    nb = 32'h2000;
    abt = 1'b1;
    run(isa_opt_pkg::OP_LOAD);
    chk({bwe, base}, {1'b0, 32'h1000});
    abt = 1'b0;
    wbk = 1'b0;
    xcb = 3'h3;
    run(isa_opt_pkg::OP_PRELOAD);
    chk({mreq, mwr, dhit, pfl}, 64'h9);
    run(isa_opt_pkg::OP_PRELOAD);
    chk(pfl, 64'h0);
    xcb = 3'h0;
    adr = 32'h20;
    run(isa_opt_pkg::OP_PRELOAD);
    chk(pfl, 64'h0);
  endtask : t_mem
  task automatic t_clean();
    int n = 0;
    xcb = 3'h7;
    adr = 32'h40;
    run(isa_opt_pkg::OP_STORE);
    adr = 32'h60;
    run(isa_opt_pkg::OP_STORE);
    run(isa_opt_pkg::OP_FLUSH);
    run(isa_opt_pkg::OP_CLEAN);
    chk(rdy, 64'h0);
    for (int i = 0; i < 40 && busy === 1'b1; i++) begin
      @(negedge clk);
      ack = wreq && !ack;
      if (ack) begin
        chk({wreq, widx}, 64'hA);
        n++;
      end
    end
    if (busy !== 1'b0) begin
      failures++;
      report_and_stop();
    end
    chk(n, 64'h1);
    xcb = 3'h0;
    shrt = 1'b1;
    evt = 8'h1;
    repeat (2) @(negedge clk);
    chk(step, 64'h2);
    chk(pmc, 64'h0000000200000002);
    shrt = 1'b0;
  endtask : t_clean
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_endian();
    t_dsp();
    t_cp();
    t_mem();
    t_clean();
    report_and_stop();
  end
endmodule : core_isa_implementation_options_test
`default_nettype wire
